// ---- core/sensor_threshold_interrupt.sv ----
`timescale 1ns/1ps
// Purpose: threshold window interrupt logic for proximity and light results
// Assumes: register port strobes and measurement strobes share i_clock
// Notes: the serial front end and measurement engines sit outside
module sensor_threshold_interrupt (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire sti_pkg::byte_t i_addr,
    input wire logic i_wr_strobe,
    input wire sti_pkg::byte_t i_wr_data,
    input wire logic i_rd_strobe,
    output sti_pkg::byte_t o_rd_data,
    output logic o_rd_valid,
    input wire logic i_prox_valid,
    input wire logic [sti_pkg::PROX_W-1:0] i_prox_result,
    input wire logic i_light_valid,
    input wire logic [sti_pkg::LIGHT_W-1:0] i_light_result,
    output logic o_prox_irq_status,
    output logic o_light_irq_status,
    output logic o_int_level,
    output logic o_int_oe
);
    import sti_pkg::*;

    typedef struct packed {
        logic [CFG_W-1:0] cfg;                 // output, polarity, source bits
        byte_t prox_up_lo;                     // proximity upper bits 7:0
        logic [PROX_HI_W-1:0] prox_up_hi;      // proximity upper bits 10:8
        byte_t prox_low_lo;                    // proximity lower bits 7:0
        logic [PROX_HI_W-1:0] prox_low_hi;     // proximity lower bits 10:8
        byte_t light_up_lo;                    // light upper low byte
        byte_t light_up_hi;                    // light upper high byte
        byte_t light_low_lo;                   // light lower low byte
        byte_t light_low_hi;                   // light lower high byte
        byte_t repeat_cnt;                     // both repeat counts
        logic prox_stat;                       // proximity interrupt status
        logic light_stat;                      // light interrupt status
        logic pin_active;                      // logical pin state
        byte_t rd_data;                        // read answer
        logic rd_valid;                        // read answer strobe
    } sti_state_s;

    sti_state_s st_reg;
    sti_state_s st_next;

    window_if #(.W(PROX_W)) prox_win ();
    window_if #(.W(LIGHT_W)) light_win ();

    logic [1:0] mode;          // interrupt source field
    logic prox_en;             // proximity may drive the pin
    logic light_en;            // light may drive the pin
    logic out_mode;            // 1 per measurement, 0 latched
    logic cfg_read;            // config register read this cycle
    logic cfg_write;           // config register write this cycle
    logic any_meas;            // either engine finished a result
    logic prox_stat_n;         // proximity status after this cycle
    logic light_stat_n;        // light status after this cycle
    logic new_event;           // enabled source met its criteria
    byte_t rd_mux;             // read data selection

    assign mode = st_reg.cfg[MODE_LIGHT_BIT:MODE_PROX_BIT];
    assign prox_en = mode[MODE_PROX_BIT];
    assign light_en = mode[MODE_LIGHT_BIT];
    assign out_mode = st_reg.cfg[CFG_OUT_BIT];
    assign cfg_read = i_rd_strobe && (i_addr == ADDR_IRQ_CFG);
    assign cfg_write = i_wr_strobe && (i_addr == ADDR_IRQ_CFG);
    assign any_meas = i_prox_valid || i_light_valid;

    // assemble windows for the checkers
    assign prox_win.result = i_prox_result;
    assign prox_win.upper = {st_reg.prox_up_hi, st_reg.prox_up_lo};
    assign prox_win.lower = {st_reg.prox_low_hi, st_reg.prox_low_lo};
    assign prox_win.meas = i_prox_valid;
    assign prox_win.repeat_cnt = st_reg.repeat_cnt[REPEAT_PROX_LSB +: RPT_W];
    assign light_win.result = i_light_result;
    assign light_win.upper = {st_reg.light_up_hi, st_reg.light_up_lo};
    assign light_win.lower = {st_reg.light_low_hi, st_reg.light_low_lo};
    assign light_win.meas = i_light_valid;
    assign light_win.repeat_cnt = st_reg.repeat_cnt[REPEAT_LIGHT_LSB +: RPT_W];

    window_check u_prox_check (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .win(prox_win)
    );

    window_check u_light_check (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .win(light_win)
    );

    // status follows each finished measurement, even with the pin off
    always_comb begin
        prox_stat_n = i_prox_valid ? prox_win.met : st_reg.prox_stat;
        light_stat_n = i_light_valid ? light_win.met : st_reg.light_stat;
        new_event = (prox_en && i_prox_valid && prox_win.met) ||
                    (light_en && i_light_valid && light_win.met);
    end

    // read data selection, unmapped offsets read zero
    always_comb begin
        case (i_addr)
            // reserved bits 7:3 read zero
            ADDR_PROX_RES_HI: rd_mux = {{(BYTE_W-PROX_HI_W){1'b0}},
                                        i_prox_result[PROX_W-1:BYTE_W]};
            // upper nibble held as zero
            ADDR_IRQ_CFG: rd_mux = {{(BYTE_W-CFG_W){1'b0}}, st_reg.cfg};
            ADDR_PROX_UP_LO: rd_mux = st_reg.prox_up_lo;
            ADDR_PROX_UP_HI: rd_mux = {{(BYTE_W-PROX_HI_W){1'b0}}, st_reg.prox_up_hi};
            ADDR_PROX_LOW_LO: rd_mux = st_reg.prox_low_lo;
            ADDR_PROX_LOW_HI: rd_mux = {{(BYTE_W-PROX_HI_W){1'b0}}, st_reg.prox_low_hi};
            ADDR_LIGHT_UP_LO: rd_mux = st_reg.light_up_lo;
            ADDR_LIGHT_UP_HI: rd_mux = st_reg.light_up_hi;
            ADDR_LIGHT_LOW_LO: rd_mux = st_reg.light_low_lo;
            ADDR_LIGHT_LOW_HI: rd_mux = st_reg.light_low_hi;
            ADDR_REPEAT: rd_mux = st_reg.repeat_cnt;
            default: rd_mux = BYTE_ZERO;
        endcase
    end

    // next state: reset, freeze, pin evaluation, register writes
    always_comb begin
        st_next = st_reg;
        if (i_sys_rst) begin
            st_next.cfg = IRQ_CFG_RESET;
            st_next.prox_up_lo = PROX_UP_LO_RESET;
            st_next.prox_up_hi = PROX_UP_HI_RESET;
            st_next.prox_low_lo = BYTE_ZERO;
            st_next.prox_low_hi = PROX_HI_ZERO;
            st_next.light_up_lo = LIGHT_UP_RESET;
            st_next.light_up_hi = LIGHT_UP_RESET;
            st_next.light_low_lo = BYTE_ZERO;
            st_next.light_low_hi = BYTE_ZERO;
            st_next.repeat_cnt = BYTE_ZERO;
            st_next.prox_stat = 1'b0;
            st_next.light_stat = 1'b0;
            st_next.pin_active = 1'b0;
            st_next.rd_data = BYTE_ZERO;
            st_next.rd_valid = 1'b0;
        end else if (i_clk_en) begin
            // read answer lands one cycle after the strobe
            st_next.rd_valid = i_rd_strobe;
            st_next.rd_data = i_rd_strobe ? rd_mux : BYTE_ZERO;
            st_next.prox_stat = prox_stat_n;
            st_next.light_stat = light_stat_n;
            // pin logic uses the config before any write this cycle
            if (mode == MODE_OFF) begin
                st_next.pin_active = 1'b0;
            end else if (out_mode) begin
                // re-evaluate after every completed measurement
                if (any_meas) begin
                    st_next.pin_active = (prox_en && prox_stat_n) ||
                                         (light_en && light_stat_n);
                end
            end else begin
                // latched: config read releases, a fresh event wins
                if (cfg_read) begin
                    st_next.pin_active = 1'b0;
                end
                if (new_event) begin
                    st_next.pin_active = 1'b1;
                end
            end
            if (i_wr_strobe) begin
                case (i_addr)
                    // reserved upper nibble is not stored
                    ADDR_IRQ_CFG: st_next.cfg = i_wr_data[CFG_W-1:0];
                    ADDR_PROX_UP_LO: st_next.prox_up_lo = i_wr_data;
                    // only bits 2:0 exist in the proximity high limit bytes
                    ADDR_PROX_UP_HI: st_next.prox_up_hi = i_wr_data[PROX_HI_W-1:0];
                    ADDR_PROX_LOW_LO: st_next.prox_low_lo = i_wr_data;
                    ADDR_PROX_LOW_HI: st_next.prox_low_hi = i_wr_data[PROX_HI_W-1:0];
                    ADDR_LIGHT_UP_LO: st_next.light_up_lo = i_wr_data;
                    ADDR_LIGHT_UP_HI: st_next.light_up_hi = i_wr_data;
                    ADDR_LIGHT_LOW_LO: st_next.light_low_lo = i_wr_data;
                    ADDR_LIGHT_LOW_HI: st_next.light_low_hi = i_wr_data;
                    ADDR_REPEAT: st_next.repeat_cnt = i_wr_data;
                    // read-only and unmapped offsets ignore writes
                    default: st_next.rd_valid = st_next.rd_valid;
                endcase
            end
        end
    end

    // state register
    always_ff @(posedge i_clock) begin
        st_reg <= st_next;
    end

    pin_drive u_pin (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .i_active(st_reg.pin_active),
        .i_polarity(st_reg.cfg[CFG_POL_BIT]),
        .i_enable(mode != MODE_OFF),
        .o_level(o_int_level),
        .o_oe(o_int_oe)
    );

    assign o_rd_data = st_reg.rd_data;
    assign o_rd_valid = st_reg.rd_valid;
    assign o_prox_irq_status = st_reg.prox_stat;
    assign o_light_irq_status = st_reg.light_stat;

    // checks on the block state
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    property p_mode_off_hiz;
        (i_clk_en && mode == MODE_OFF) |=> !o_int_oe;
    endproperty
    a_mode_off_hiz: assert property (p_mode_off_hiz)
        else $error("pin driven while source field is zero");

    property p_src_gate;
        (i_clk_en && mode == MODE_PROX && i_light_valid && !i_prox_valid &&
         !st_reg.pin_active && !st_reg.prox_stat && !cfg_write) |=> !st_reg.pin_active;
    endproperty
    a_src_gate: assert property (p_src_gate)
        else $error("light result raised pin in proximity-only mode");

    property p_latch_hold;
        (i_clk_en && !out_mode && mode != MODE_OFF && st_reg.pin_active &&
         !cfg_read && !cfg_write) |=> st_reg.pin_active;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latched pin released without config read");

    property p_per_meas;
        (i_clk_en && out_mode && mode != MODE_OFF && !any_meas && !cfg_write)
        |=> $stable(st_reg.pin_active);
    endproperty
    a_per_meas: assert property (p_per_meas)
        else $error("pin changed without a measurement");

    property p_polarity;
        (i_clk_en && mode != MODE_OFF) |=>
        (o_int_level == ($past(st_reg.cfg[CFG_POL_BIT]) ?
                         $past(st_reg.pin_active) : !$past(st_reg.pin_active)));
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("pin level does not follow polarity");

    property p_reset_cfg;
        $past(i_sys_rst) |-> (st_reg.cfg == IRQ_CFG_RESET && !o_rd_valid);
    endproperty
    a_reset_cfg: assert property (p_reset_cfg)
        else $error("config not at reset value after reset");

    property p_prox_out;
        (i_clk_en && i_prox_valid && prox_win.repeat_cnt == RUN_ZERO &&
         (i_prox_result > prox_win.upper || i_prox_result < prox_win.lower))
        |=> o_prox_irq_status;
    endproperty
    a_prox_out: assert property (p_prox_out)
        else $error("proximity outside window not flagged");

    property p_light_in;
        (i_clk_en && i_light_valid && i_light_result <= light_win.upper &&
         i_light_result >= light_win.lower) |=> !o_light_irq_status;
    endproperty
    a_light_in: assert property (p_light_in)
        else $error("light inside window flagged");

    property p_hi_readback;
        (i_clk_en && i_rd_strobe && i_addr == ADDR_PROX_RES_HI) |=>
        (o_rd_valid && o_rd_data == {5'h00, $past(i_prox_result[PROX_W-1:BYTE_W])});
    endproperty
    a_hi_readback: assert property (p_hi_readback)
        else $error("proximity result high byte read wrong");

    property p_prox_up_reset;
        $past(i_sys_rst) |-> (prox_win.upper == {PROX_UP_HI_RESET, PROX_UP_LO_RESET} &&
                              light_win.lower == {BYTE_ZERO, BYTE_ZERO});
    endproperty
    a_prox_up_reset: assert property (p_prox_up_reset)
        else $error("limits not at reset values");

    c_latched_set: cover property (!out_mode && $rose(st_reg.pin_active));
    c_latched_clear: cover property (!out_mode && st_reg.pin_active && cfg_read);
    c_per_meas_drop: cover property (out_mode && $fell(st_reg.pin_active));
    c_repeat_met: cover property (i_prox_valid && prox_win.met &&
                                  prox_win.repeat_cnt > 4'h1);
    // a fresh event in the same cycle as the releasing read keeps the pin set
    c_set_over_clear: cover property (!out_mode && cfg_read && new_event);
endmodule

// ---- shared/sti_pkg.sv ----
// Purpose: constants and types for the sensor threshold interrupt block
// Assumes: one clock, synchronous active-high reset, byte-wide register port
// Notes: register offsets are the byte addresses of the register port
//
// What this block does
// - mode 00 floats pin, status still updates
// - mode bits pick proximity, light or both
// - latched output held until config read
// - per-measurement output re-evaluated after each result
// - polarity bit sets pin active level
// - interrupt config resets to 0x08
// - proximity outside limits flags proximity condition
// - light outside limits flags light condition
// - proximity limits eleven bits, split low/high
// - proximity upper resets 0x7FF, lower zero
// - light limits sixteen bits, reset FFFF/0000
// - proximity result high holds bits 10:8
// - repeat count needs consecutive outside results
// - status bits set when criteria met
package sti_pkg;
    typedef logic [7:0] byte_t;

    // widths
    localparam int BYTE_W = 8;
    localparam int PROX_W = 11;
    localparam int LIGHT_W = 16;
    localparam int PROX_HI_W = 3;
    localparam int RPT_W = 4;
    localparam int CFG_W = 4;

    // register offsets
    localparam byte_t ADDR_PROX_RES_HI = 8'h8E;
    localparam byte_t ADDR_IRQ_CFG = 8'h8F;
    localparam byte_t ADDR_PROX_UP_LO = 8'h90;
    localparam byte_t ADDR_PROX_UP_HI = 8'h91;
    localparam byte_t ADDR_PROX_LOW_LO = 8'h92;
    localparam byte_t ADDR_PROX_LOW_HI = 8'h93;
    localparam byte_t ADDR_LIGHT_UP_LO = 8'h97;
    localparam byte_t ADDR_LIGHT_UP_HI = 8'h98;
    localparam byte_t ADDR_LIGHT_LOW_LO = 8'h99;
    localparam byte_t ADDR_LIGHT_LOW_HI = 8'h9A;
    localparam byte_t ADDR_REPEAT = 8'h9E;

    // interrupt config fields
    localparam int CFG_POL_BIT = 2;
    localparam int CFG_OUT_BIT = 3;
    localparam int MODE_PROX_BIT = 0;
    localparam int MODE_LIGHT_BIT = 1;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_PROX = 2'h1;
    localparam logic [1:0] MODE_LIGHT = 2'h2;
    localparam logic [1:0] MODE_BOTH = 2'h3;

    // repeat count fields
    localparam int REPEAT_PROX_LSB = 4;
    localparam int REPEAT_LIGHT_LSB = 0;

    // reset values
    localparam logic [CFG_W-1:0] IRQ_CFG_RESET = 4'h8;
    localparam byte_t PROX_UP_LO_RESET = 8'hFF;
    localparam logic [PROX_HI_W-1:0] PROX_UP_HI_RESET = 3'h7;
    localparam byte_t LIGHT_UP_RESET = 8'hFF;
    localparam byte_t BYTE_ZERO = 8'h00;
    localparam logic [PROX_HI_W-1:0] PROX_HI_ZERO = 3'h0;
    localparam logic [RPT_W-1:0] RUN_ZERO = 4'h0;
    localparam logic [RPT_W-1:0] RUN_MAX = 4'hF;
    localparam logic PIN_IDLE_LEVEL = 1'b1;
endpackage

// ---- shared/window_if.sv ----
`timescale 1ns/1ps
// Purpose: carries one source's result, limits and verdict to its checker
// Assumes: result and limits share one width
// Notes: ctrl side is the register block, check side the comparator
interface window_if #(
    parameter int W = 16
);
    logic [W-1:0] result;      // latest measurement
    logic [W-1:0] upper;       // assembled upper limit
    logic [W-1:0] lower;       // assembled lower limit
    logic meas;                // new measurement strobe
    logic [3:0] repeat_cnt;    // consecutive outside results needed
    logic out;                 // result lies outside the window
    logic met;                 // interrupt criteria met this measurement

    modport check (
        input result, upper, lower, meas, repeat_cnt,
        output out, met
    );
    modport ctrl (
        output result, upper, lower, meas, repeat_cnt,
        input out, met
    );
endinterface

// ---- core/window_check.sv ----
`timescale 1ns/1ps
// Purpose: window compare and consecutive-outside counter for one source
// Assumes: meas is a one-cycle strobe on the same clock
// Notes: out and met are combinational, valid in the strobe cycle
module window_check (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    window_if.check win
);
    import sti_pkg::*;

    typedef struct packed {
        logic [RPT_W-1:0] run;     // outside results seen in a row
    } wc_state_s;

    wc_state_s st_reg;
    wc_state_s st_next;
    logic out;
    logic met;
    logic [RPT_W-1:0] run_inc;

    // compare, count and next state
    always_comb begin
        // strict compare on the full assembled values
        out = (win.result > win.upper) || (win.result < win.lower);
        // saturate so a long run never wraps back below the count
        run_inc = (st_reg.run == RUN_MAX) ? RUN_MAX : RPT_W'(st_reg.run + 1'b1);
        // zero count lets every outside result through
        met = out && ((win.repeat_cnt == RUN_ZERO) || (run_inc >= win.repeat_cnt));
        st_next = st_reg;
        if (i_sys_rst) begin
            st_next.run = RUN_ZERO;
        end else if (i_clk_en && win.meas) begin
            // an inside result breaks the run
            st_next.run = out ? run_inc : RUN_ZERO;
        end
    end

    // state register
    always_ff @(posedge i_clock) begin
        st_reg <= st_next;
    end

    assign win.out = out;
    assign win.met = met;

    property p_run_clears;
        @(posedge i_clock) disable iff (i_sys_rst)
        (i_clk_en && win.meas && !out) |=> (st_reg.run == RUN_ZERO);
    endproperty
    a_run_clears: assert property (p_run_clears)
        else $error("run count not cleared by inside result");

    // first and second outside results of a run of three must not pass
    property p_run_blocks;
        @(posedge i_clock) disable iff (i_sys_rst)
        (i_clk_en && win.meas && out && win.repeat_cnt == 4'h3 && st_reg.run < 4'h2)
        |-> !met;
    endproperty
    a_run_blocks: assert property (p_run_blocks)
        else $error("criteria met before third outside result");
endmodule

// ---- core/pin_drive.sv ----
`timescale 1ns/1ps
// Purpose: registered interrupt pin level and enable
// Assumes: active, polarity and enable come from the same clock
// Notes: one cycle of latency from the block state to the pin
module pin_drive (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic i_active,
    input wire logic i_polarity,
    input wire logic i_enable,
    output logic o_level,
    output logic o_oe
);
    import sti_pkg::*;

    typedef struct packed {
        logic level;     // pin value when driven
        logic oe;        // high while the pin is driven
    } pd_state_s;

    pd_state_s st_reg;
    pd_state_s st_next;

    // polarity map and enable
    always_comb begin
        st_next = st_reg;
        if (i_sys_rst) begin
            st_next.level = PIN_IDLE_LEVEL;
            st_next.oe = 1'b0;
        end else if (i_clk_en) begin
            // polarity 0 drives low when active
            st_next.level = i_polarity ? i_active : !i_active;
            // disabled mode releases the pin entirely
            st_next.oe = i_enable;
        end
    end

    // state register
    always_ff @(posedge i_clock) begin
        st_reg <= st_next;
    end

    assign o_level = st_reg.level;
    assign o_oe = st_reg.oe;
endmodule

// ---- dv/int_pin_host.sv ----
// Purpose: host end of the interrupt pin, resolves the wire level seen
// Assumes: board pull-up on the pin
// Notes: a floated pin reads high, never the last driven value
`timescale 1ns/1ps
module int_pin_host (
    input wire logic i_level,
    input wire logic i_oe,
    output logic o_pin
);
    // pull-up wins whenever the device lets go of the pin
    assign o_pin = i_oe ? i_level : 1'b1;
endmodule

// ---- dv/tb_top.sv ----
// Purpose: register and measurement sequences for the threshold interrupt
// Assumes: strobes raised at falling edge, one cycle wide
// Notes: pin judged through the host model, so a float reads high
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_top;
    import sti_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic pv = 1'b0;
    logic lv = 1'b0;
    byte_t addr = 8'h00;
    byte_t wdat = 8'h00;
    logic [10:0] pr = 11'h000;
    logic [15:0] lr = 16'h0000;
    byte_t rdat;
    logic rval, ps, ls, lvl, oe, pin;
    int fails = 0;
    int check_count = 0;
    // reset table, then window limits: prox 0x010..0x100, light 0x0010..0x1000
    byte_t ra[10] = '{8'h8F, 8'h90, 8'h91, 8'h92, 8'h93, 8'h97, 8'h98, 8'h99, 8'h9A, 8'h9E};
    byte_t rv[10] = '{8'h08, 8'hFF, 8'h07, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
    byte_t wa[7] = '{8'h90, 8'h91, 8'h92, 8'h93, 8'h97, 8'h98, 8'h99};
    byte_t wv[7] = '{8'h00, 8'h01, 8'h10, 8'h00, 8'h00, 8'h10, 8'h10};
    // boundary results: inside, just above, just below, inside
    logic [10:0] pt[4] = '{11'h100, 11'h101, 11'h00F, 11'h010};
    logic [15:0] lt[4] = '{16'h1000, 16'h1001, 16'h000F, 16'h0010};

    always #12.5 clock = ~clock;

    sensor_threshold_interrupt dut (.i_clock(clock), .i_sys_rst(rst), .i_clk_en(en),
        .i_addr(addr), .i_wr_strobe(wr), .i_wr_data(wdat), .i_rd_strobe(rd),
        .o_rd_data(rdat), .o_rd_valid(rval), .i_prox_valid(pv), .i_prox_result(pr),
        .i_light_valid(lv), .i_light_result(lr), .o_prox_irq_status(ps),
        .o_light_irq_status(ls), .o_int_level(lvl), .o_int_oe(oe));
    int_pin_host host (.i_level(lvl), .i_oe(oe), .o_pin(pin));

    // one write pulse
    task automatic wr_reg(input byte_t a, input byte_t d);
        @(negedge clock);
        addr = a;
        wdat = d;
        wr = 1'b1;
        @(negedge clock);
        wr = 1'b0;
    endtask

    // one read pulse; a missing valid turns the answer unknown
    task automatic rd_reg(input byte_t a, output byte_t d);
        @(negedge clock);
        addr = a;
        rd = 1'b1;
        @(negedge clock);
        rd = 1'b0;
        d = rval ? rdat : 8'hXX;
    endtask

    // one measurement; returns once the pin has had its two cycles
    task automatic meas(input logic [10:0] p, input logic l, input logic [15:0] lres);
        @(negedge clock);
        pv = 1'b1;
        pr = p;
        lv = l;
        lr = lres;
        @(negedge clock);
        pv = 1'b0;
        lv = 1'b0;
        @(negedge clock);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // watchdog, far beyond the fewer than two hundred cycles the sequence needs
    initial begin
        #125000;
        fails++;
        test_done;
    end

    initial begin
        byte_t d;
        logic e;
        repeat (10) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        foreach (ra[i]) begin
            rd_reg(ra[i], d);
            `CHK("reset value", rv[i], d)
        end
        `CHK("oe after reset", 1'b0, oe)
        // reserved bits written as zero, as software must
        wr_reg(ADDR_PROX_UP_HI, 8'h05);
        rd_reg(ADDR_PROX_UP_HI, d);
        `CHK("prox upper high", 8'h05, d)
        // a write strobe while the clock enable is low must be ignored
        @(negedge clock);
        en = 1'b0;
        addr = ADDR_PROX_LOW_LO;
        wdat = 8'h55;
        wr = 1'b1;
        @(negedge clock);
        wr = 1'b0;
        en = 1'b1;
        rd_reg(ADDR_PROX_LOW_LO, d);
        `CHK("frozen write", 8'h00, d)
        pr = 11'h5A3;
        rd_reg(ADDR_PROX_RES_HI, d);
        `CHK("result high", 3'h5, d[2:0])
        $display("test registers done");
        foreach (wa[i]) wr_reg(wa[i], wv[i]);
        // mode off: status moves, pin stays floated
        meas(11'h101, 1'b1, 16'h0010);
        `CHK("prox status off", 1'b1, ps)
        `CHK("pin off", 1'b1, pin)
        foreach (pt[i]) begin
            meas(pt[i], 1'b1, lt[i]);
            `CHK("prox status", (i == 1 || i == 2), ps)
            `CHK("light status", (i == 1 || i == 2), ls)
        end
        $display("test windows done");
        // every mode and polarity, per-measurement output
        for (int c = 0; c < 8; c++) begin
            wr_reg(ADDR_IRQ_CFG, {5'h01, c[2:0]});
            for (int k = 0; k < 2; k++) begin
                meas(k ? 11'h100 : 11'h101, 1'b1, k ? 16'h1001 : 16'h0010);
                e = (c[1:0] == 2'h0) ? 1'b1 : (c[k] ~^ c[2]);
                `CHK("pin level", e, pin)
                `CHK("pin oe", (c[1:0] != 2'h0), oe)
            end
        end
        $display("test modes done");
        // latched output held across an inside result until config read
        wr_reg(ADDR_IRQ_CFG, 8'h01);
        // the write keeps the previous mode's active state; a read clears it first
        rd_reg(ADDR_IRQ_CFG, d);
        @(negedge clock);
        `CHK("latched idle", 1'b1, pin)
        meas(11'h101, 1'b0, 16'h0000);
        `CHK("latched set", 1'b0, pin)
        meas(11'h100, 1'b0, 16'h0000);
        `CHK("latched held", 1'b0, pin)
        rd_reg(ADDR_IRQ_CFG, d);
        `CHK("cfg read", 8'h01, d)
        repeat (2) @(negedge clock);
        `CHK("latched cleared", 1'b1, pin)
        $display("test latch done");
        // proximity needs three outside results in a row
        wr_reg(ADDR_IRQ_CFG, 8'h09);
        wr_reg(ADDR_REPEAT, 8'h30);
        meas(11'h100, 1'b0, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            meas(11'h101, 1'b0, 16'h0000);
            `CHK("repeat status", (i == 2), ps)
        end
        `CHK("repeat pin", 1'b0, pin)
        $display("test repeat done");
        test_done;
    end
endmodule
